// File: rtl/cpuex_top.sv
`timescale 1ns/1ps
// How it works
// - borrow-subtract leaves acc minus memory in the chosen accumulator
// - borrow-subtract also takes away the carry flag
// - sign widen fills upper acc from bit 7 of lower; sets N,Z only
// - byte store writes one location; N,Z from data, V cleared
// - word store writes high byte at address, low byte next
// - byte subtract sets N,Z,V, carry as borrow
// - word subtract takes D minus the 16-bit operand in one cycle; half-carry untouched
// - traps set E, then push PC,U,Y,X low first, DP,B,A,CC
// - first trap masks I and F, then uses its vector
// - second trap loads PC from its vector, masks untouched
// - third trap uses its own vector, masks untouched
// - sync stops processing until an interrupt input is active
// - any interrupt, masked or not, ends sync
// - interrupt taken only if enabled and held three cycles
// - buses float while synchronising
// - copy source from bits 7-4, destination from bits 3-0
// - codes D,X,Y,U,S,PC,A,B,CC,DP; others undefined
// - check leaves operand alone; N,Z set, V cleared
// - stacked E tells the return what was saved
module cpuex_top
    import cpuex_pkg::*;
(
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic start,
    input wire cpuex_op_e op,
    input wire logic acc_sel_b,
    input wire logic [15:0] ea,
    input wire logic [15:0] operand,
    input wire logic [7:0] postbyte,
    input wire logic [3:0] store_reg,
    input wire logic [7:0] mem_rdata,
    input wire logic irq_n,
    input wire logic firq_n,
    input wire logic nmi_n,
    output logic [15:0] mem_addr_o,
    output logic [15:0] mem_addr_oe,
    output logic [7:0] mem_wdata_o,
    output logic [7:0] mem_wdata_oe,
    output logic mem_we,
    output logic mem_re,
    output logic busy,
    output logic done,
    output logic take_irq,
    output logic [7:0] acc_a,
    output logic [7:0] acc_b,
    output logic [15:0] idx_x,
    output logic [15:0] idx_y,
    output logic [15:0] usp,
    output logic [15:0] ssp,
    output logic [15:0] pc,
    output logic [7:0] flags_register,
    output logic [7:0] direct_page_reg
);
    // ==========================================
    // reset release
    logic rst_s1_r;
    logic rst_n_r;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r <= rst_s1_r;
        end
    end

    // ==========================================
    // helpers
    typedef enum {ST_IDLE, ST_WR, ST_RD, ST_SYNC} cpuex_state_e;
    cpuex_state_e state_r;
    cpuex_op_e op_r;
    logic [3:0] cnt_r;
    logic [7:0] rd_hi_r;
    logic [1:0] irq_len_r;
    logic any_irq;
    cpuex_bus_if bus ();

    function automatic logic [15:0] reg_read(input logic [3:0] code,
                                             input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic [15:0] x,
                                             input logic [15:0] y,
                                             input logic [15:0] u,
                                             input logic [15:0] s,
                                             input logic [15:0] p,
                                             input logic [7:0] c,
                                             input logic [7:0] d);
        unique case (code)
            RC_D: reg_read = {a, b};
            RC_X: reg_read = x;
            RC_Y: reg_read = y;
            RC_U: reg_read = u;
            RC_S: reg_read = s;
            RC_PC: reg_read = p;
            RC_A: reg_read = {8'hFF, a};
            RC_B: reg_read = {8'hFF, b};
            RC_CC: reg_read = {8'hFF, c};
            RC_DP: reg_read = {8'hFF, d};
            default: reg_read = 16'hFFFF;
        endcase
    endfunction

    // stack byte n of the full-state push, n = 0 is pushed first
    function automatic logic [7:0] push_byte(input logic [3:0] n);
        unique case (n)
            4'h0: push_byte = pc[7:0];
            4'h1: push_byte = pc[15:8];
            4'h2: push_byte = usp[7:0];
            4'h3: push_byte = usp[15:8];
            4'h4: push_byte = idx_y[7:0];
            4'h5: push_byte = idx_y[15:8];
            4'h6: push_byte = idx_x[7:0];
            4'h7: push_byte = idx_x[15:8];
            4'h8: push_byte = direct_page_reg;
            4'h9: push_byte = acc_b;
            4'hA: push_byte = acc_a;
            default: push_byte = flags_register;
        endcase
    endfunction

    // ==========================================
    // arithmetic
    logic [15:0] src_val;
    logic [15:0] alu_lhs;
    logic [15:0] diff;
    logic a_n, a_z, a_v, a_c;
    logic [7:0] acc_sel;
    assign acc_sel = acc_sel_b ? acc_b : acc_a;
    assign alu_lhs = (op == CPUEX_OP_SUB16) ? {acc_a, acc_b}
                                            : {8'h00, acc_sel};
    assign src_val = reg_read(postbyte[7:4], acc_a, acc_b, idx_x, idx_y,
                              usp, ssp, pc, flags_register,
                              direct_page_reg);

    cpuex_alu u_alu (
        .lhs(alu_lhs),
        .rhs(operand),
        .borrow_in((op == CPUEX_OP_SBC) & flags_register[CC_C]),
        .wide(op == CPUEX_OP_SUB16),
        .diff(diff),
        .neg(a_n),
        .zero(a_z),
        .ovf(a_v),
        .borrow(a_c)
    );

    logic [15:0] st_val;
    assign st_val = reg_read(store_reg, acc_a, acc_b, idx_x, idx_y, usp,
                             ssp, pc, flags_register, direct_page_reg);
    assign any_irq = !irq_n | !firq_n | !nmi_n;

    // ==========================================
    // sequencer and register file
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= ST_IDLE;
            op_r <= CPUEX_OP_NONE;
            cnt_r <= 4'h0;
            rd_hi_r <= 8'h00;
            acc_a <= 8'h00;
            acc_b <= 8'h00;
            idx_x <= WORD_RST;
            idx_y <= WORD_RST;
            usp <= WORD_RST;
            ssp <= WORD_RST;
            pc <= WORD_RST;
            flags_register <= CC_RST;
            direct_page_reg <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            take_irq <= 1'b0;
            bus.addr <= 16'h0000;
            bus.wdata <= 8'h00;
            bus.we <= 1'b0;
            bus.re <= 1'b0;
            mem_addr_oe <= 16'h0000;
            mem_wdata_oe <= 8'h00;
        end else begin
            done <= 1'b0;
            take_irq <= 1'b0;
            bus.we <= 1'b0;
            bus.re <= 1'b0;
            mem_wdata_oe <= 8'h00;
            unique case (state_r)
                ST_IDLE: begin
                    mem_addr_oe <= 16'hFFFF;
                    if (start) begin
                        op_r <= op;
                        unique case (op)
                            CPUEX_OP_SBC, CPUEX_OP_SUB8: begin
                                if (acc_sel_b) acc_b <= diff[7:0];
                                else acc_a <= diff[7:0];
                                flags_register[CC_N] <= a_n;
                                flags_register[CC_Z] <= a_z;
                                flags_register[CC_V] <= a_v;
                                flags_register[CC_C] <= a_c;
                                done <= 1'b1;
                            end
                            CPUEX_OP_SUB16: begin
                                {acc_a, acc_b} <= diff;
                                flags_register[CC_N] <= a_n;
                                flags_register[CC_Z] <= a_z;
                                flags_register[CC_V] <= a_v;
                                flags_register[CC_C] <= a_c;
                                done <= 1'b1;
                            end
                            CPUEX_OP_SIGN: begin
                                acc_a <= acc_b[7] ? 8'hFF : 8'h00;
                                flags_register[CC_N] <= acc_b[7];
                                flags_register[CC_Z] <=
                                    (acc_b[7] ? 8'hFF : 8'h00) == 8'h00 &&
                                    acc_b == 8'h00;
                                done <= 1'b1;
                            end
                            CPUEX_OP_CHECK: begin
                                flags_register[CC_N] <= operand[7];
                                flags_register[CC_Z] <=
                                    operand[7:0] == 8'h00;
                                flags_register[CC_V] <= 1'b0;
                                done <= 1'b1;
                            end
                            CPUEX_OP_COPY: begin
                                unique case (postbyte[3:0])
                                    RC_D: {acc_a, acc_b} <= src_val;
                                    RC_X: idx_x <= src_val;
                                    RC_Y: idx_y <= src_val;
                                    RC_U: usp <= src_val;
                                    RC_S: ssp <= src_val;
                                    RC_PC: pc <= src_val;
                                    RC_A: acc_a <= src_val[7:0];
                                    RC_B: acc_b <= src_val[7:0];
                                    RC_CC: flags_register <= src_val[7:0];
                                    RC_DP: direct_page_reg <= src_val[7:0];
                                    default: ;
                                endcase
                                done <= 1'b1;
                            end
                            CPUEX_OP_ST8: begin
                                bus.addr <= ea;
                                bus.wdata <= st_val[7:0];
                                bus.we <= 1'b1;
                                mem_wdata_oe <= 8'hFF;
                                flags_register[CC_N] <= st_val[7];
                                flags_register[CC_Z] <=
                                    st_val[7:0] == 8'h00;
                                flags_register[CC_V] <= 1'b0;
                                state_r <= ST_WR;
                                cnt_r <= 4'hB;
                                busy <= 1'b1;
                            end
                            CPUEX_OP_ST16: begin
                                bus.addr <= ea;
                                bus.wdata <= st_val[15:8];
                                bus.we <= 1'b1;
                                mem_wdata_oe <= 8'hFF;
                                flags_register[CC_N] <= st_val[15];
                                flags_register[CC_Z] <=
                                    st_val == 16'h0000;
                                flags_register[CC_V] <= 1'b0;
                                state_r <= ST_WR;
                                cnt_r <= 4'hA;
                                busy <= 1'b1;
                            end
                            CPUEX_OP_TRAP1, CPUEX_OP_TRAP2,
                            CPUEX_OP_TRAP3: begin
                                flags_register[CC_E] <= 1'b1;
                                cnt_r <= 4'h0;
                                state_r <= ST_WR;
                                busy <= 1'b1;
                            end
                            CPUEX_OP_SYNC: begin
                                state_r <= ST_SYNC;
                                mem_addr_oe <= 16'h0000;
                                busy <= 1'b1;
                            end
                            default: ;
                        endcase
                    end
                end
                ST_WR: begin
                    if (op_r == CPUEX_OP_ST8) begin
                        state_r <= ST_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end else if (op_r == CPUEX_OP_ST16) begin
                        if (cnt_r == 4'hA) begin
                            bus.addr <= ea + 16'h0001;
                            bus.wdata <= st_val[7:0];
                            bus.we <= 1'b1;
                            mem_wdata_oe <= 8'hFF;
                            cnt_r <= 4'hB;
                        end else begin
                            state_r <= ST_IDLE;
                            busy <= 1'b0;
                            done <= 1'b1;
                        end
                    end else if (cnt_r < 4'(STACK_BYTES)) begin
                        ssp <= ssp - 16'h0001;
                        bus.addr <= ssp - 16'h0001;
                        bus.wdata <= push_byte(cnt_r);
                        bus.we <= 1'b1;
                        mem_wdata_oe <= 8'hFF;
                        cnt_r <= cnt_r + 4'h1;
                    end else begin
                        if (op_r == CPUEX_OP_TRAP1) begin
                            flags_register[CC_I] <= 1'b1;
                            flags_register[CC_F] <= 1'b1;
                        end
                        bus.addr <= (op_r == CPUEX_OP_TRAP1) ? VEC_TRAP1 :
                            (op_r == CPUEX_OP_TRAP2) ? VEC_TRAP2 :
                            VEC_TRAP3;
                        bus.re <= 1'b1;
                        cnt_r <= 4'h0;
                        state_r <= ST_RD;
                    end
                end
                ST_RD: begin
                    // data of a read stands the cycle after the strobe
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == 4'h0) begin
                        bus.addr <= bus.addr + 16'h0001;
                        bus.re <= 1'b1;
                    end else if (cnt_r == 4'h1) begin
                        rd_hi_r <= bus.rdata;
                    end else begin
                        pc <= {rd_hi_r, bus.rdata};
                        state_r <= ST_IDLE;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
                ST_SYNC: begin
                    mem_addr_oe <= 16'h0000;
                    if (any_irq) begin
                        state_r <= ST_IDLE;
                        mem_addr_oe <= 16'hFFFF;
                        busy <= 1'b0;
                        done <= 1'b1;
                    end
                end
            endcase
            if (state_r != ST_SYNC && irq_len_r == 2'(SYNC_LONG_CYC - 1) &&
                op_r == CPUEX_OP_SYNC && any_irq &&
                ((!nmi_n) || (!firq_n && !flags_register[CC_F]) ||
                 (!irq_n && !flags_register[CC_I])))
                take_irq <= 1'b1;
        end
    end

    // consecutive cycles an interrupt line has been low
    always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) irq_len_r <= 2'h0;
        else if (!any_irq) irq_len_r <= 2'h0;
        else if (irq_len_r != 2'h3) irq_len_r <= irq_len_r + 2'h1;
    end

    assign bus.rdata = mem_rdata;
    assign mem_addr_o = bus.addr;
    assign mem_wdata_o = bus.wdata;
    assign mem_we = bus.we;
    assign mem_re = bus.re;

    // ==========================================
    // checks
    a_sync_float: assert property (@(posedge sys_clk)
        disable iff (!rst_n_r)
        state_r == ST_SYNC |-> mem_addr_oe == 16'h0000 &&
        mem_wdata_oe == 8'h00)
        else $error("bus driven in sync");
    a_sync_exit: assert property (@(posedge sys_clk)
        disable iff (!rst_n_r)
        state_r == ST_SYNC && any_irq |=> state_r == ST_IDLE)
        else $error("sync not ended by interrupt");
    a_trap_sets_e: assert property (@(posedge sys_clk)
        disable iff (!rst_n_r)
        state_r == ST_IDLE && start &&
        op inside {CPUEX_OP_TRAP1, CPUEX_OP_TRAP2, CPUEX_OP_TRAP3}
        |=> flags_register[CC_E])
        else $error("trap did not set E");
    a_trap2_masks: assert property (@(posedge sys_clk)
        disable iff (!rst_n_r)
        op_r inside {CPUEX_OP_TRAP2, CPUEX_OP_TRAP3} && state_r != ST_IDLE
        |=> $stable(flags_register[CC_I]) && $stable(flags_register[CC_F]))
        else $error("second or third trap touched masks");
    a_trap1_masks: assert property (@(posedge sys_clk)
        disable iff (!rst_n_r)
        op_r == CPUEX_OP_TRAP1 && done |-> flags_register[CC_I] &&
        flags_register[CC_F])
        else $error("first trap left masks open");
    a_st8_v_clear: assert property (@(posedge sys_clk)
        disable iff (!rst_n_r)
        state_r == ST_IDLE && start && op == CPUEX_OP_ST8
        |=> mem_we && !flags_register[CC_V] ##1 done)
        else $error("byte store wrong");
    a_st16_pair: assert property (@(posedge sys_clk)
        disable iff (!rst_n_r)
        state_r == ST_IDLE && start && op == CPUEX_OP_ST16
        |=> mem_we && mem_addr_o == $past(ea)
        ##1 mem_we && mem_addr_o == $past(ea, 2) + 16'h0001)
        else $error("word store order wrong");
    a_sign_fill: assert property (@(posedge sys_clk)
        disable iff (!rst_n_r)
        state_r == ST_IDLE && start && op == CPUEX_OP_SIGN
        |=> acc_a == {8{$past(acc_b[7])}})
        else $error("sign widen wrong");
    c_trap1: cover property (@(posedge sys_clk) op_r == CPUEX_OP_TRAP1
        && done);
    c_sync_take: cover property (@(posedge sys_clk) take_irq);
    c_st16: cover property (@(posedge sys_clk) op_r == CPUEX_OP_ST16
        && done);
endmodule

// File: rtl/cpuex_pkg.sv
package cpuex_pkg;

    // ==========================================
    // operation selector
    typedef enum logic [3:0] {
        CPUEX_OP_NONE,
        CPUEX_OP_SBC,
        CPUEX_OP_SIGN,
        CPUEX_OP_ST8,
        CPUEX_OP_ST16,
        CPUEX_OP_SUB8,
        CPUEX_OP_SUB16,
        CPUEX_OP_TRAP1,
        CPUEX_OP_TRAP2,
        CPUEX_OP_TRAP3,
        CPUEX_OP_SYNC,
        CPUEX_OP_COPY,
        CPUEX_OP_CHECK
    } cpuex_op_e;

    // ==========================================
    // flags register bit positions
    localparam int CC_C = 0;
    localparam int CC_V = 1;
    localparam int CC_Z = 2;
    localparam int CC_N = 3;
    localparam int CC_I = 4;
    localparam int CC_H = 5;
    localparam int CC_F = 6;
    localparam int CC_E = 7;

    // ==========================================
    // register codes for the copy postbyte
    localparam logic [3:0] RC_D = 4'h0;
    localparam logic [3:0] RC_X = 4'h1;
    localparam logic [3:0] RC_Y = 4'h2;
    localparam logic [3:0] RC_U = 4'h3;
    localparam logic [3:0] RC_S = 4'h4;
    localparam logic [3:0] RC_PC = 4'h5;
    localparam logic [3:0] RC_A = 4'h8;
    localparam logic [3:0] RC_B = 4'h9;
    localparam logic [3:0] RC_CC = 4'hA;
    localparam logic [3:0] RC_DP = 4'hB;

    // ==========================================
    // trap vectors (high byte address)
    localparam logic [15:0] VEC_TRAP1 = 16'hFFFA;
    localparam logic [15:0] VEC_TRAP2 = 16'hFFF4;
    localparam logic [15:0] VEC_TRAP3 = 16'hFFF2;

    // ==========================================
    // reset values and timing
    localparam logic [7:0] CC_RST = 8'h50;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam int SYNC_LONG_CYC = 3;
    localparam int STACK_BYTES = 12;

endpackage

// File: rtl/cpuex_bus_if.sv
`timescale 1ns/1ps
interface cpuex_bus_if;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic [7:0] rdata;
    modport ctl (output addr, output wdata, output we, output re,
                 input rdata);
    modport mem (input addr, input wdata, input we, input re,
                 output rdata);
endinterface

// File: rtl/cpuex_alu.sv
`timescale 1ns/1ps
module cpuex_alu
    import cpuex_pkg::*;
(
    input wire logic [15:0] lhs,
    input wire logic [15:0] rhs,
    input wire logic borrow_in,
    input wire logic wide,
    output logic [15:0] diff,
    output logic neg,
    output logic zero,
    output logic ovf,
    output logic borrow
);
    logic [16:0] full;
    logic sl;
    logic sr;
    logic sd;

    always_comb begin
        full = {1'b0, lhs} - {1'b0, rhs} - {16'h0000, borrow_in};
        if (wide) begin
            diff = full[15:0];
            borrow = full[16];
            sl = lhs[15];
            sr = rhs[15];
            sd = full[15];
            zero = (full[15:0] == 16'h0000);
        end else begin
            diff = {8'h00, full[7:0]};
            borrow = {1'b0, lhs[7:0]} <
                     ({1'b0, rhs[7:0]} + {8'h00, borrow_in});
            sl = lhs[7];
            sr = rhs[7];
            sd = full[7];
            zero = (full[7:0] == 8'h00);
        end
        neg = sd;
        // overflow when operands differ in sign and result follows rhs
        ovf = (sl ^ sr) & (sl ^ sd);
    end
endmodule

// File: bench/cpuex_mem_model.sv
`timescale 1ns/1ps
// ==========================================
// memory partner: byte store, answers a read in the next cycle only
module cpuex_mem_model (
    input wire logic sys_clk,
    input wire logic [15:0] mem_addr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic mem_we,
    input wire logic mem_re,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    initial mem_rdata = 8'h00;
    always @(posedge sys_clk) begin
        if (mem_we) begin
            mem[mem_addr_o] <= mem_wdata_o;
        end
        // released data line toggles so stale bytes never look valid
        mem_rdata <= mem_re ? mem[mem_addr_o] : ~mem_rdata;
    end
endmodule

// File: bench/cpu_exec_sub_store_swi_sync_tb_top.sv
`timescale 1ns/1ps
module cpu_exec_sub_store_swi_sync_tb_top
    import cpuex_pkg::*;
;
    logic sys_clk = 0, arst_n = 0, start = 0, acc_sel_b = 0;
    logic irq_n = 1, firq_n = 1, nmi_n = 1, mem_we, mem_re, busy, done;
    logic take_irq, seen_irq;
    cpuex_op_e op = CPUEX_OP_NONE;
    logic [15:0] ea = 16'h0000, operand = 16'h0000;
    logic [7:0] postbyte = 8'h00, mem_rdata, mem_wdata_o, mem_wdata_oe;
    logic [3:0] store_reg = 4'h0;
    logic [15:0] mem_addr_o, mem_addr_oe, idx_x, idx_y, usp, ssp, pc;
    logic [7:0] acc_a, acc_b, flags_register, direct_page_reg;
    int num_errors = 0, tests_run = 0, cyc = 0;
    always #50 sys_clk = ~sys_clk;
    cpuex_top uut (.sys_clk(sys_clk), .arst_n(arst_n), .start(start),
        .op(op), .acc_sel_b(acc_sel_b), .ea(ea), .operand(operand),
        .postbyte(postbyte), .store_reg(store_reg), .mem_rdata(mem_rdata),
        .irq_n(irq_n), .firq_n(firq_n), .nmi_n(nmi_n),
        .mem_addr_o(mem_addr_o), .mem_addr_oe(mem_addr_oe),
        .mem_wdata_o(mem_wdata_o), .mem_wdata_oe(mem_wdata_oe),
        .mem_we(mem_we), .mem_re(mem_re), .busy(busy), .done(done),
        .take_irq(take_irq), .acc_a(acc_a), .acc_b(acc_b), .idx_x(idx_x),
        .idx_y(idx_y), .usp(usp), .ssp(ssp), .pc(pc),
        .flags_register(flags_register),
        .direct_page_reg(direct_page_reg));
    cpuex_mem_model mdl (.sys_clk(sys_clk), .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o), .mem_we(mem_we), .mem_re(mem_re),
        .mem_rdata(mem_rdata));
    // ==========================================
    // checking and run control
    task automatic chk(string name, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            summarize();
        end
    end
    // start one op and wait, bounded, for its done pulse
    task automatic run(cpuex_op_e o);
        int i;
        @(posedge sys_clk);
        start <= 1'b1;
        op <= o;
        @(posedge sys_clk);
        start <= 1'b0;
        seen_irq = 1'b0;
        // a one-cycle op shows done just after the edge that took start
        for (i = 0; i < 40; i++) begin
            #1;
            if (take_irq === 1'b1) seen_irq = 1'b1;
            if (done === 1'b1) break;
            @(posedge sys_clk);
        end
        chk("done", 16'h1, {15'h0, done});
    endtask
    // ==========================================
    // scenarios
    task automatic t_arith();
        operand <= 16'h0001;
        run(CPUEX_OP_SUB8);
        chk("sub a", 16'hFF, {8'h0, acc_a});
        chk("sub nzvc", 16'h9, {12'h0, flags_register[3:0]});
        operand <= 16'h000F;
        run(CPUEX_OP_SBC);
        chk("sbc a", 16'hEF, {8'h0, acc_a});
        chk("sbc nzvc", 16'h8, {12'h0, flags_register[3:0]});
        operand <= 16'h0000;
        run(CPUEX_OP_CHECK);
        chk("check nzvc", 16'h4, {12'h0, flags_register[3:0]});
    endtask
    task automatic t_copy_sign_store();
        postbyte <= {RC_A, RC_B};
        run(CPUEX_OP_COPY);
        chk("copy b", 16'hEF, {8'h0, acc_b});
        run(CPUEX_OP_SIGN);
        chk("sign a", 16'hFF, {8'h0, acc_a});
        chk("sign vc", 16'h0, {14'h0, flags_register[1:0]});
        store_reg <= RC_D;
        ea <= 16'h1000;
        run(CPUEX_OP_ST16);
        chk("st hi", 16'hFF, {8'h0, mdl.mem[16'h1000]});
        chk("st lo", 16'hEF, {8'h0, mdl.mem[16'h1001]});
        chk("st nzvc", 16'h8, {12'h0, flags_register[3:0]});
        store_reg <= RC_DP;
        ea <= 16'h1002;
        run(CPUEX_OP_ST8);
        chk("st8", 16'h0, {8'h0, mdl.mem[16'h1002]});
        chk("st8 nzvc", 16'h4, {12'h0, flags_register[3:0]});
    endtask
    task automatic t_trap2();
        postbyte <= {RC_D, RC_S};
        run(CPUEX_OP_COPY);
        chk("copy s", 16'hFFEF, ssp);
        run(CPUEX_OP_TRAP2);
        chk("trap pc", 16'h1234, pc);
        chk("trap sp", 16'hFFE3, ssp);
        chk("push a", 16'hFF, {8'h0, mdl.mem[16'hFFE4]});
        chk("push b", 16'hEF, {8'h0, mdl.mem[16'hFFE5]});
        chk("push e", 16'h1, {15'h0, mdl.mem[16'hFFE3][CC_E]});
        chk("masks", 16'h3, {14'h0, flags_register[CC_F],
            flags_register[CC_I]});
    endtask
    task automatic t_trap13();
        postbyte <= {RC_DP, RC_CC};
        run(CPUEX_OP_COPY);
        chk("copy cc", 16'h0, {8'h0, flags_register});
        run(CPUEX_OP_TRAP3);
        chk("trap3 pc", 16'h9ABC, pc);
        chk("trap3 masks", 16'h0, {14'h0, flags_register[CC_F],
            flags_register[CC_I]});
        run(CPUEX_OP_TRAP1);
        chk("trap1 pc", 16'h5678, pc);
        chk("push pc", 16'h9ABC,
            {mdl.mem[16'hFFD5], mdl.mem[16'hFFD6]});
        chk("trap1 masks", 16'h3, {14'h0, flags_register[CC_F],
            flags_register[CC_I]});
        chk("trap1 sp", 16'hFFCB, ssp);
        operand <= 16'hFFF0;
        run(CPUEX_OP_SUB16);
        chk("sub16 d", 16'hFFFF, {acc_a, acc_b});
        chk("sub16 nzvc", 16'h9, {12'h0, flags_register[3:0]});
    endtask
    task automatic t_sync(logic use_nmi, logic exp_take);
        @(posedge sys_clk);
        start <= 1'b1;
        op <= CPUEX_OP_SYNC;
        @(posedge sys_clk);
        start <= 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk("sync busy", 16'h1, {15'h0, busy});
        chk("sync float", 16'h0000, mem_addr_oe);
        // irq is masked here, nmi never is; either ends sync
        if (use_nmi) nmi_n <= 1'b0;
        else irq_n <= 1'b0;
        seen_irq = 1'b0;
        repeat (4) begin
            @(posedge sys_clk);
            #1;
            if (take_irq === 1'b1) seen_irq = 1'b1;
        end
        irq_n <= 1'b1;
        nmi_n <= 1'b1;
        chk("sync done", 16'h0, {15'h0, busy});
        chk("irq take", {15'h0, exp_take}, {15'h0, seen_irq});
    endtask
    initial begin
        mdl.mem[16'hFFF4] = 8'h12;
        mdl.mem[16'hFFF5] = 8'h34;
        mdl.mem[VEC_TRAP1] = 8'h56;
        mdl.mem[VEC_TRAP1 + 16'h0001] = 8'h78;
        mdl.mem[VEC_TRAP3] = 8'h9A;
        mdl.mem[VEC_TRAP3 + 16'h0001] = 8'hBC;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_arith();
        t_copy_sign_store();
        t_trap2();
        t_trap13();
        t_sync(1'b0, 1'b0);
        t_sync(1'b1, 1'b1);
        summarize();
    end
endmodule
